// file: hw/duisr_pkg.sv
// Constants shared by the interrupt status/mask block and its helpers.
// Assumes a 4-bit register address bus and 8-bit data, one device clock.
package duisr_pkg;

  // ----------------------------------------
  // Register bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADR_INPUT_CHANGE = 4'h4;
  localparam logic [3:0] ADR_INT_STATUS = 4'h5;
  localparam logic [3:0] ADR_INT_MASK = 4'h5;
  localparam logic [3:0] ADR_CMD_A = 4'h2;
  localparam logic [3:0] ADR_CMD_B = 4'ha;
  localparam logic [3:0] ADR_CT_START = 4'he;
  localparam logic [3:0] ADR_CT_STOP = 4'hf;

  // ----------------------------------------
  // Command field in a channel command write
  // ----------------------------------------
  localparam int CMD_LSB = 4;
  localparam int CMD_W = 4;
  localparam logic [3:0] CMD_RST_BRK_CHG = 4'h5;

  // ----------------------------------------
  // Status and mask bit positions
  // ----------------------------------------
  localparam int BIT_TX_A = 0;
  localparam int BIT_RX_A = 1;
  localparam int BIT_BRK_A = 2;
  localparam int BIT_CT_RDY = 3;
  localparam int BIT_TX_B = 4;
  localparam int BIT_RX_B = 5;
  localparam int BIT_BRK_B = 6;
  localparam int BIT_IN_CHG = 7;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------
  // FIFO fill levels (16 entries)
  // ----------------------------------------
  localparam int CNT_W = 5;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] LVL_ONE = 5'h01;
  localparam logic [4:0] LVL_QUARTER = 5'h04;
  localparam logic [4:0] LVL_HALF = 5'h08;
  localparam logic [4:0] LVL_FULL = 5'h10;
  localparam logic [1:0] SEL_LVL0 = 2'h0;
  localparam logic [1:0] SEL_LVL1 = 2'h1;
  localparam logic [1:0] SEL_LVL2 = 2'h2;

endpackage

// file: hw/duisr_cmd_if.sv
// Bus events carried from the pin synchroniser into the status core.
// Assumes both ends sit on the same device clock.
`timescale 1ns/1ps
interface duisr_cmd_if;
  import duisr_pkg::*;
  logic rd_pulse;
  logic wr_pulse;
  logic rd_active;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;

  modport bus
  (
    output rd_pulse, wr_pulse, rd_active, addr, wdata
  );
  modport core
  (
    input rd_pulse, wr_pulse, rd_active, addr, wdata
  );
endinterface

// file: hw/duisr_bus_sync.sv
// Host bus pin synchroniser: two flops per pin, then strobe edge pulses.
// Assumes address and data are stable while a strobe is held low.
`timescale 1ns/1ps
module duisr_bus_sync
  import duisr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // Host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic [DATA_W-1:0] data_pin,
  // Events towards the core
  duisr_cmd_if.bus ev
);

  logic [2+ADDR_W+DATA_W:0] s1_q;
  logic [2+ADDR_W+DATA_W:0] s2_q;
  logic rd_prev_q;
  logic wr_prev_q;
  wire logic [2+ADDR_W+DATA_W:0] pins_raw = {cs_n, rd_n, wr_n, addr_pin, data_pin};
  wire logic cs_s_n = s2_q[2+ADDR_W+DATA_W];
  wire logic rd_s_n = s2_q[1+ADDR_W+DATA_W];
  wire logic wr_s_n = s2_q[ADDR_W+DATA_W];
  wire logic rd_now = ~cs_s_n & ~rd_s_n;
  wire logic wr_now = ~cs_s_n & ~wr_s_n;

  // ----------------------------------------
  // Two-flop synchroniser, first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '1;
      s2_q <= '1;
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      rd_prev_q <= rd_now;
      wr_prev_q <= wr_now;
    end
  end

  // One pulse per strobe, so a long read acts once on side effects
  assign ev.rd_pulse = rd_now & ~rd_prev_q & ce;
  assign ev.wr_pulse = wr_now & ~wr_prev_q & ce;
  assign ev.rd_active = rd_prev_q;
  assign ev.addr = s2_q[ADDR_W+DATA_W-1:DATA_W];
  assign ev.wdata = s2_q[DATA_W-1:0];

endmodule

// file: hw/duisr_ct_ready.sv
// Counter-ready status bit for the counter/timer.
// Assumes ct_zero pulses for one clock each time the count reaches zero.
`timescale 1ns/1ps
module duisr_ct_ready
  import duisr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // Counter/timer events
  input wire logic timer_mode,
  input wire logic ct_zero,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  // Status
  output logic ready_q
);

  logic phase_q;
  // Timer mode: one square-wave cycle is two zero arrivals
  wire logic set_rdy = ct_zero & (~timer_mode | phase_q);
  wire logic ready_d = set_rdy | (ready_q & ~stop_cmd);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_q <= 1'b0;
      phase_q <= 1'b0;
    end
    else if (ce)
    begin
      // Set wins over a stop in the same cycle
      ready_q <= ready_d;
      // Stop leaves the phase alone so the square wave keeps its rhythm
      if (start_cmd)
        phase_q <= 1'b0;
      else if (ct_zero & timer_mode)
        phase_q <= ~phase_q;
    end
  end

  a_timer_half_skip: assert property (@(posedge clock) disable iff (!arst_n)
    ce & timer_mode & ct_zero & ~phase_q & ~start_cmd & ~ready_q |=> ~ready_q)
    else $error("ready set on first half of square wave");
  a_stop_clears_rdy: assert property (@(posedge clock) disable iff (!arst_n)
    ce & stop_cmd & ~ct_zero |=> ~ready_q)
    else $error("stop command did not clear counter ready");
  a_count_term_set: assert property (@(posedge clock) disable iff (!arst_n)
    ce & ~timer_mode & ct_zero |=> ready_q)
    else $error("terminal count did not set counter ready");

endmodule

// file: hw/duisr_top.sv
// Interrupt status and mask block of a two-channel serial device.
// Assumes the host bus pins are asynchronous to clock and that all
// event and level inputs from the channels and counter/timer are
// produced on clock.
//
// Function
// - Bit 6 sets on a channel B break start or end and clears only on the B reset-break cmd.
// - Bit 2 sets on a channel A break start or end and clears only on the A reset-break cmd.
// - Bit 5 shows channel B receive level reached or B receiver watchdog timeout.
// - Bit 1 shows channel A receive level reached or A receiver watchdog timeout.
// - Bit 4 shows channel B transmit interrupt per the level chosen by mode bits 5:4.
// - Bit 0 shows channel A transmit interrupt per the level chosen by mode bits 5:4.
// - In counter mode bit 3 sets at terminal count and clears on a stop-counter cmd.
// - In timer mode bit 3 sets on every second zero arrival and clears on a stop cmd.
// - In timer mode a stop command only clears bit 3 and the timer keeps running.
// - The interrupt output asserts when any status bit and its mask bit are both one.
// - The mask never gates the status read-back or the programmable output pins.
// - Mask bits 7..0 enable the status sources at the same positions, 1 enabled.
// - Receive interrupt bits are made apart from each channel's receiver-ready bit.
// - Bit 7 sets on an enabled input change and clears when the change reg is read.
// - The interrupt output is active low and reset clears the status to zero.
`timescale 1ns/1ps
module duisr_top
  import duisr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Channel A receive and transmit state
  input wire logic [CNT_W-1:0] rx_a_fill,
  input wire logic [CNT_W-1:0] tx_a_fill,
  input wire logic rx_a_watchdog,
  input wire logic rx_a_break_edge,
  input wire logic [1:0] rx_a_level_sel,
  input wire logic [1:0] tx_a_level_sel,
  // Channel B receive and transmit state
  input wire logic [CNT_W-1:0] rx_b_fill,
  input wire logic [CNT_W-1:0] tx_b_fill,
  input wire logic rx_b_watchdog,
  input wire logic rx_b_break_edge,
  input wire logic [1:0] rx_b_level_sel,
  input wire logic [1:0] tx_b_level_sel,
  // Counter/timer
  input wire logic ct_timer_mode,
  input wire logic ct_zero,
  output logic ct_start_cmd,
  output logic ct_stop_cmd,
  // Input port change
  input wire logic [3:0] ip_change,
  input wire logic [3:0] ip_change_en,
  input wire logic [DATA_W-1:0] input_change_reg,
  // Interrupt and status view
  output logic irq_out_n,
  output logic rx_a_irq,
  output logic rx_b_irq,
  output logic tx_a_irq,
  output logic tx_b_irq
);

  // ----------------------------------------
  // Level functions
  // ----------------------------------------
  // Receive threshold: fill count has reached the selected level
  function automatic logic rx_level_hit(input logic [CNT_W-1:0] fill, input logic [1:0] sel);
    logic [CNT_W-1:0] lvl;
    lvl = LVL_FULL;
    case (sel)
      SEL_LVL0: lvl = LVL_ONE;
      SEL_LVL1: lvl = LVL_QUARTER;
      SEL_LVL2: lvl = LVL_HALF;
      default: lvl = LVL_FULL;
    endcase
    return (fill >= lvl);
  endfunction

  // Transmit threshold: free space has reached the selected level
  function automatic logic tx_level_hit(input logic [CNT_W-1:0] fill, input logic [1:0] sel);
    logic [CNT_W-1:0] room;
    logic [CNT_W-1:0] lvl;
    room = FIFO_DEPTH - fill;
    lvl = LVL_ONE;
    case (sel)
      SEL_LVL0: lvl = LVL_FULL;
      SEL_LVL1: lvl = LVL_HALF;
      SEL_LVL2: lvl = LVL_QUARTER;
      default: lvl = LVL_ONE;
    endcase
    return (room >= lvl);
  endfunction

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  duisr_cmd_if ev ();

  duisr_bus_sync u_sync
  (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .addr_pin(addr_pin),
    .data_pin(data_in),
    .ev(ev)
  );

  wire logic [CMD_W-1:0] cmd_code = ev.wdata[CMD_LSB +: CMD_W];
  wire logic cmd_a_wr = ev.wr_pulse & (ev.addr == ADR_CMD_A);
  wire logic cmd_b_wr = ev.wr_pulse & (ev.addr == ADR_CMD_B);
  wire logic clr_brk_a = cmd_a_wr & (cmd_code == CMD_RST_BRK_CHG);
  wire logic clr_brk_b = cmd_b_wr & (cmd_code == CMD_RST_BRK_CHG);
  wire logic mask_wr = ev.wr_pulse & (ev.addr == ADR_INT_MASK);
  wire logic status_rd = ev.rd_pulse & (ev.addr == ADR_INT_STATUS);
  wire logic ipc_rd = ev.rd_pulse & (ev.addr == ADR_INPUT_CHANGE);
  wire logic start_rd = ev.rd_pulse & (ev.addr == ADR_CT_START);
  wire logic stop_rd = ev.rd_pulse & (ev.addr == ADR_CT_STOP);

  // ----------------------------------------
  // Source conditions
  // ----------------------------------------
  // Built from fill levels, not from the receiver-ready flag
  wire logic rx_a_hit = rx_level_hit(rx_a_fill, rx_a_level_sel) | rx_a_watchdog;
  wire logic rx_b_hit = rx_level_hit(rx_b_fill, rx_b_level_sel) | rx_b_watchdog;
  wire logic tx_a_hit = tx_level_hit(tx_a_fill, tx_a_level_sel);
  wire logic tx_b_hit = tx_level_hit(tx_b_fill, tx_b_level_sel);
  wire logic ipc_set = |(ip_change & ip_change_en);
  wire logic ct_rdy;

  duisr_ct_ready u_ct
  (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .timer_mode(ct_timer_mode),
    .ct_zero(ct_zero),
    .start_cmd(start_rd),
    .stop_cmd(stop_rd),
    .ready_q(ct_rdy)
  );

  // ----------------------------------------
  // Status and mask registers
  // ----------------------------------------
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] mask_q;
  logic [DATA_W-1:0] rdata_q;

  always_comb
  begin
    status_d = status_q;
    status_d[BIT_TX_A] = tx_a_hit;
    status_d[BIT_RX_A] = rx_a_hit;
    status_d[BIT_TX_B] = tx_b_hit;
    status_d[BIT_RX_B] = rx_b_hit;
    // Sticky bits: a new event wins over a clear in the same cycle
    status_d[BIT_BRK_A] = rx_a_break_edge | (status_q[BIT_BRK_A] & ~clr_brk_a);
    status_d[BIT_BRK_B] = rx_b_break_edge | (status_q[BIT_BRK_B] & ~clr_brk_b);
    status_d[BIT_CT_RDY] = ct_rdy;
    status_d[BIT_IN_CHG] = ipc_set | (status_q[BIT_IN_CHG] & ~ipc_rd);
  end

  // Reads return the unmasked status, mask is write-only
  wire logic [DATA_W-1:0] rd_mux =
    (ev.addr == ADR_INT_STATUS) ? status_q :
    (ev.addr == ADR_INPUT_CHANGE) ? input_change_reg : RDATA_RST;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q <= STATUS_RST;
      mask_q <= MASK_RST;
      rdata_q <= RDATA_RST;
    end
    else if (ce)
    begin
      status_q <= status_d;
      if (mask_wr)
        mask_q <= ev.wdata;
      if (ev.rd_pulse)
        rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Combinational from flops so a mask write takes effect at once
  assign irq_out_n = ~|(status_q & mask_q);
  assign data_out = rdata_q;
  assign data_oe = ev.rd_active;
  assign ct_start_cmd = start_rd;
  // The timer must keep running, so stop reaches it only in counter mode
  assign ct_stop_cmd = stop_rd & ~ct_timer_mode;
  // Unmasked copies for the programmable output pins
  assign rx_a_irq = status_q[BIT_RX_A];
  assign rx_b_irq = status_q[BIT_RX_B];
  assign tx_a_irq = status_q[BIT_TX_A];
  assign tx_b_irq = status_q[BIT_TX_B];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_brk_b_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    status_q[BIT_BRK_B] & ~(ce & clr_brk_b) |=> status_q[BIT_BRK_B])
    else $error("break B status dropped without its command");
  a_brk_b_set: assert property (@(posedge clock) disable iff (!arst_n)
    ce & rx_b_break_edge |=> status_q[BIT_BRK_B])
    else $error("break B edge not recorded");
  a_brk_a_clear: assert property (@(posedge clock) disable iff (!arst_n)
    ce & clr_brk_a & ~rx_a_break_edge |=> ~status_q[BIT_BRK_A])
    else $error("break A status not cleared by command");
  a_rx_b_track: assert property (@(posedge clock) disable iff (!arst_n)
    ce & rx_b_watchdog |=> status_q[BIT_RX_B])
    else $error("receive B watchdog not shown");
  a_rx_a_track: assert property (@(posedge clock) disable iff (!arst_n)
    ce |=> status_q[BIT_RX_A] == $past(rx_a_hit))
    else $error("receive A status does not follow its source");
  a_tx_level_view: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (tx_b_fill == '0) |=> status_q[BIT_TX_B])
    else $error("empty transmit B fifo not interrupting");
  a_tx_a_track: assert property (@(posedge clock) disable iff (!arst_n)
    ce |=> tx_a_irq == $past(tx_a_hit))
    else $error("transmit A status does not follow its source");
  a_stop_timer_runs: assert property (@(posedge clock) disable iff (!arst_n)
    stop_rd & ct_timer_mode |-> ~ct_stop_cmd)
    else $error("stop command reached a running timer");
  a_irq_gate_on: assert property (@(posedge clock) disable iff (!arst_n)
    ce & mask_wr & |(ev.wdata & status_d) |=> ~irq_out_n)
    else $error("enabled pending source not interrupting");
  a_irq_masked_off: assert property (@(posedge clock) disable iff (!arst_n)
    ce & mask_wr & (ev.wdata == '0) |=> irq_out_n [*2])
    else $error("interrupt asserted with all sources masked");
  a_read_unmasked: assert property (@(posedge clock) disable iff (!arst_n)
    ce & status_rd |=> data_out == $past(status_q) && data_oe)
    else $error("status read-back differs from true status");
  a_ipc_read_clear: assert property (@(posedge clock) disable iff (!arst_n)
    ce & ipc_rd & ~ipc_set |=> ~status_q[BIT_IN_CHG])
    else $error("input change status not cleared by read");

  // ----------------------------------------
  // Source and sticky-bit assertions
  // ----------------------------------------
  // Fill extremes give level expectations that need no threshold decode
  a_brk_a_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    status_q[BIT_BRK_A] & ~clr_brk_a |=> status_q[BIT_BRK_A])
    else $error("break A status dropped without its command");
  a_brk_a_set: assert property (@(posedge clock) disable iff (!arst_n)
    ce & rx_a_break_edge |=> status_q[BIT_BRK_A])
    else $error("break A edge not recorded");
  a_brk_b_clear: assert property (@(posedge clock) disable iff (!arst_n)
    ce & clr_brk_b & ~rx_b_break_edge |=> ~status_q[BIT_BRK_B])
    else $error("break B status not cleared by command");
  a_rx_a_full: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (rx_a_fill >= LVL_FULL) |=> rx_a_irq)
    else $error("full receive A fifo not interrupting");
  a_rx_a_empty: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (rx_a_fill == '0) & ~rx_a_watchdog |=> ~status_q[BIT_RX_A])
    else $error("empty receive A fifo interrupting");
  a_rx_b_full: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (rx_b_fill >= LVL_FULL) |=> rx_b_irq)
    else $error("full receive B fifo not interrupting");
  a_rx_b_empty: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (rx_b_fill == '0) & ~rx_b_watchdog |=> ~status_q[BIT_RX_B])
    else $error("empty receive B fifo interrupting");
  a_tx_a_full: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (tx_a_fill == FIFO_DEPTH) |=> ~status_q[BIT_TX_A])
    else $error("full transmit A fifo interrupting");
  a_tx_a_empty: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (tx_a_fill == '0) |=> tx_a_irq)
    else $error("empty transmit A fifo not interrupting");
  a_tx_b_full: assert property (@(posedge clock) disable iff (!arst_n)
    ce & (tx_b_fill == FIFO_DEPTH) |=> ~tx_b_irq)
    else $error("full transmit B fifo interrupting");
  a_ipc_set: assert property (@(posedge clock) disable iff (!arst_n)
    ce & ipc_set |=> status_q[BIT_IN_CHG])
    else $error("enabled input change not recorded");
  a_ipc_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    status_q[BIT_IN_CHG] & ~ipc_rd |=> status_q[BIT_IN_CHG])
    else $error("input change status dropped without a read");

  // Bus side effects
  a_mask_write_lands: assert property (@(posedge clock) disable iff (!arst_n)
    ce & mask_wr |=> mask_q == $past(ev.wdata))
    else $error("mask write did not land");
  a_stop_clear_view: assert property (@(posedge clock) disable iff (!arst_n)
    ce & stop_rd & ~ct_zero ##1 ce |=> ~status_q[BIT_CT_RDY])
    else $error("stop command did not clear counter ready status");
  a_read_drives_bus: assert property (@(posedge clock) disable iff (!arst_n)
    ev.rd_pulse |=> data_oe)
    else $error("read strobe did not drive the data bus");
  a_start_one_pulse: assert property (@(posedge clock) disable iff (!arst_n)
    ct_start_cmd |=> ~ct_start_cmd)
    else $error("start command longer than one cycle");

endmodule

// file: testbench/duisr_host_model.sv
// Host CPU model: strobed register reads and writes on the device pins.
// Assumes the block answers every read by raising data_oe.
`timescale 1ns/1ps
module duisr_host_model
  import duisr_pkg::*;
(
  // Clock
  input wire logic clock,
  // Bus pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [ADDR_W-1:0] addr_pin,
  output logic [DATA_W-1:0] data_in,
  // Read answer
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr_pin = 4'h0;
    data_in = 8'h00;
  end

  // Address and data outlive the strobe, since the strobe is seen late
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    addr_pin = a;
    data_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (3) @(negedge clock);
    // Released lines show the inverse so stale values never look valid
    addr_pin = ~a;
    data_in = ~d;
    repeat (2) @(negedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge clock);
    addr_pin = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (n = 0; n < 16 && !ok; n++)
    begin
      @(negedge clock);
      if (data_oe === 1'b1)
      begin
        d = data_out;
        ok = 1'b1;
      end
    end
    @(negedge clock);
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (3) @(negedge clock);
    addr_pin = ~a;
    for (n = 0; n < 16 && data_oe !== 1'b0; n++)
      @(negedge clock);
    if (data_oe !== 1'b0)
      ok = 1'b0;
    repeat (2) @(negedge clock);
  endtask
endmodule

// file: testbench/duisr_top_tb_top.sv
// Self-checking bench for the interrupt status and mask block.
// Assumes the host model issues every register access.
`timescale 1ns/1ps
module duisr_top_tb_top;
  import duisr_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, rd_n, wr_n, data_oe, irq_out_n, ct_start_cmd, ct_stop_cmd, ok, ce;
  logic [3:0] addr_pin, ip_change, ip_change_en;
  logic [7:0] data_in, data_out, input_change_reg, sticky, mask_m, rdv;
  logic [4:0] rx_a_fill, tx_a_fill, rx_b_fill, tx_b_fill;
  logic [1:0] rx_a_level_sel, tx_a_level_sel, rx_b_level_sel, tx_b_level_sel;
  logic rx_a_watchdog, rx_b_watchdog, rx_a_break_edge, rx_b_break_edge;
  logic ct_timer_mode, ct_zero, rx_a_irq, rx_b_irq, tx_a_irq, tx_b_irq;
  int failures = 0;
  int num_checks = 0;
  int starts = 0;
  int stops = 0;

  always #4 clock = ~clock;

  always @(negedge clock)
  begin
    if (ct_start_cmd === 1'b1)
      starts++;
    if (ct_stop_cmd === 1'b1)
      stops++;
  end

  duisr_top duisr_top_inst (.clock, .arst_n, .ce, .cs_n, .rd_n, .wr_n, .addr_pin,
    .data_in, .data_out, .data_oe, .rx_a_fill, .tx_a_fill, .rx_a_watchdog, .rx_a_break_edge,
    .rx_a_level_sel, .tx_a_level_sel, .rx_b_fill, .tx_b_fill, .rx_b_watchdog,
    .rx_b_break_edge, .rx_b_level_sel, .tx_b_level_sel, .ct_timer_mode, .ct_zero,
    .ct_start_cmd, .ct_stop_cmd, .ip_change, .ip_change_en, .input_change_reg, .irq_out_n,
    .rx_a_irq, .rx_b_irq, .tx_a_irq, .tx_b_irq);

  duisr_host_model duisr_host_model_inst (.clock, .cs_n, .rd_n, .wr_n, .addr_pin, .data_in,
    .data_out, .data_oe);

  // ------------------------------
  // Expectations and checking
  // ------------------------------
  function automatic logic rx_lvl(logic [4:0] f, logic [1:0] s, logic w);
    logic [4:0] t;
    t = (s == 2'h0) ? 5'h01 : (s == 2'h1) ? 5'h04 : (s == 2'h2) ? 5'h08 : 5'h10;
    return w | (f >= t);
  endfunction

  // Fill limit for the chosen free-space level of a 16-entry FIFO
  function automatic logic tx_lvl(logic [4:0] f, logic [1:0] s);
    logic [4:0] t;
    t = (s == 2'h0) ? 5'h00 : (s == 2'h1) ? 5'h08 : (s == 2'h2) ? 5'h0c : 5'h0f;
    return f <= t;
  endfunction

  function automatic logic [7:0] exp_stat();
    return sticky | {2'h0, rx_lvl(rx_b_fill, rx_b_level_sel, rx_b_watchdog),
      tx_lvl(tx_b_fill, tx_b_level_sel), 2'h0,
      rx_lvl(rx_a_fill, rx_a_level_sel, rx_a_watchdog), tx_lvl(tx_a_fill, tx_a_level_sel)};
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    duisr_host_model_inst.rd(a, d, ok);
    if (!ok)
    begin
      check("read_timeout", 8'h00, 8'h01);
      results();
    end
  endtask

  task automatic wm(input logic [7:0] m);
    mask_m = m;
    duisr_host_model_inst.wr(ADR_INT_MASK, m);
  endtask

  task automatic chk_stat();
    logic [7:0] e;
    logic [7:0] v;
    repeat (3) @(negedge clock);
    e = exp_stat();
    v = {4'h0, rx_b_irq, tx_b_irq, rx_a_irq, tx_a_irq};
    check("irq_n", {7'h0, irq_out_n}, {7'h0, ~|(e & mask_m)});
    check("irq_view", v, {4'h0, e[5:4], e[1:0]});
    rd(ADR_INT_STATUS, rdv);
    check("status", rdv, e);
  endtask

  // One-cycle event pulse: 2 break A, 3 counter zero, 6 break B, else pin change
  task automatic ev(input int k);
    @(negedge clock);
    case (k)
      2: rx_a_break_edge = 1'b1;
      3: ct_zero = 1'b1;
      6: rx_b_break_edge = 1'b1;
      default: ip_change = 4'h2;
    endcase
    @(negedge clock);
    {rx_a_break_edge, ct_zero, rx_b_break_edge, ip_change} = 7'h00;
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    {rx_a_fill, rx_b_fill, rx_a_level_sel, rx_b_level_sel} = 14'h0000;
    {tx_a_level_sel, tx_b_level_sel, tx_a_fill, tx_b_fill} = 14'h0210;
    {rx_a_watchdog, rx_b_watchdog, ct_timer_mode} = 3'h0;
    {rx_a_break_edge, ct_zero, rx_b_break_edge, ip_change} = 7'h00;
    ip_change_en = 4'hd;
    input_change_reg = 8'h00;
    sticky = 8'h00;
    mask_m = 8'h00;
    ce = 1'b1;
    void'($urandom(32'h1682c16a));
    repeat (20) @(negedge clock);
    check("irq_n_rst", {7'h0, irq_out_n}, 8'h01);
    check("oe_rst", {7'h0, data_oe}, 8'h00);
    arst_n = 1'b1;
    chk_stat();
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      {rx_a_fill, tx_a_fill} = {5'($urandom_range(16)), 5'($urandom_range(16))};
      {rx_b_fill, tx_b_fill} = {5'($urandom_range(16)), 5'($urandom_range(16))};
      if (i < 3)
        {rx_a_fill, tx_b_fill} = {5'(i * 8), 5'(16 - i * 8)};
      {rx_a_level_sel, tx_a_level_sel, rx_b_level_sel, tx_b_level_sel} = 8'($urandom);
      {rx_a_watchdog, rx_b_watchdog} = (i > 8) ? 2'($urandom) : 2'h0;
      wm(8'($urandom));
      chk_stat();
    end
    $display("test levels done");
    {rx_a_fill, rx_b_fill, rx_a_watchdog, rx_b_watchdog} = 12'h000;
    {tx_a_fill, tx_b_fill} = 10'h210;
    // Clock enable low must swallow an event pulse
    ce = 1'b0;
    ev(2);
    ce = 1'b1;
    chk_stat();
    ev(2);
    ev(6);
    ev(3);
    ev(7);
    sticky = 8'h4c;
    chk_stat();
    ip_change_en = 4'h2;
    ev(7);
    sticky = 8'hcc;
    for (int i = 0; i < 8; i++)
    begin
      wm(8'(1 << i));
      chk_stat();
    end
    $display("test mask done");
    duisr_host_model_inst.wr(ADR_CMD_A, 8'h40);
    chk_stat();
    duisr_host_model_inst.wr(ADR_CMD_A, 8'h50);
    sticky = 8'hc8;
    chk_stat();
    duisr_host_model_inst.wr(ADR_CMD_B, 8'h50);
    sticky = 8'h88;
    chk_stat();
    input_change_reg = 8'($urandom);
    rd(ADR_INPUT_CHANGE, rdv);
    check("change_reg", rdv, input_change_reg);
    sticky = 8'h08;
    chk_stat();
    rd(4'h3, rdv);
    check("unmapped", rdv, 8'h00);
    rd(ADR_CT_STOP, rdv);
    sticky = 8'h00;
    chk_stat();
    check("stops", 8'(stops), 8'h01);
    $display("test clears done");
    ct_timer_mode = 1'b1;
    rd(ADR_CT_START, rdv);
    check("starts", 8'(starts), 8'h01);
    ev(3);
    chk_stat();
    ev(3);
    sticky = 8'h08;
    chk_stat();
    rd(ADR_CT_STOP, rdv);
    sticky = 8'h00;
    chk_stat();
    check("stops_timer", 8'(stops), 8'h01);
    // The timer keeps its phase across the stop, so one more zero is silent
    ev(3);
    chk_stat();
    ev(3);
    sticky = 8'h08;
    chk_stat();
    $display("test timer done");
    results();
  end
endmodule
